// ==== design/icvt_defs.svh ====
/*
 * Offsets, field positions and timing counts of the current-trim and
 * voltage-target register bank. Assumes a 40 MHz system clock.
 */
`ifndef ICVT_DEFS_SVH
`define ICVT_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ICVT_OFS_CUR_CAL 8'hA5
`define ICVT_OFS_VOUT_TGT 8'hA6
`define ICVT_OFS_VID_RB 8'hA7

// ****************************************************************
// Fields
// ****************************************************************
`define ICVT_GAIN_MSB 7
`define ICVT_GAIN_LSB 4
`define ICVT_OFS_MSB 3
`define ICVT_OFS_LSB 0
`define ICVT_SRC_I2C 2'h2
`define ICVT_OFS_NEG_BASE 12'h008
`define ICVT_OFS_POS_BASE 12'h007
`define ICVT_OFS_TOP_CODE 4'hF

// ****************************************************************
// Timing
// ****************************************************************
`define ICVT_CLK_HZ 40000000
`define ICVT_UPDATE_NS 190000
`define ICVT_UPDATE_CYC ((`ICVT_UPDATE_NS / 1000) * (`ICVT_CLK_HZ / 1000000))
`define ICVT_SLEW_DIV 4

`endif

// ==== design/icvt_pkg.sv ====
/*
 * Types of the current-trim and voltage-target register bank.
 * Assumes nothing of its surroundings.
 */
package icvt_pkg;
  typedef enum logic [1:0] {
    ICVT_OFF = 2'h0,
    ICVT_SOFT_START = 2'h1,
    ICVT_RUN = 2'h3,
    ICVT_SOFT_STOP = 2'h2
  } icvt_pwr_t;
  typedef logic [7:0] icvt_byte_t;
endpackage

// ==== design/icvt_ramp.sv ====
/*
 * Steps the commanded level toward the target at a quarter of the fast slew.
 * Assumes fast_slew gives clocks per step at the fast rate, zero meaning one.
 */
`timescale 1ns/10ps
`default_nettype none
`include "icvt_defs.svh"
module icvt_ramp (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Ramp link
  icvt_ramp_if.ramp rmp
);
  import icvt_pkg::*;
  logic [7:0] tgt, next_tgt, lvl, next_lvl;
  logic [5:0] cnt, next_cnt;
  logic [6:0] period;

  always_comb begin
    // The slowest period, 64 clocks, needs seven bits.
    period = 7'({3'h0, rmp.fast_slew} + 7'h1) * 7'(`ICVT_SLEW_DIV);
    next_tgt = tgt;
    next_lvl = lvl;
    next_cnt = cnt;
    if (rmp.load) begin
      next_tgt = rmp.target;
      next_cnt = 6'h0;
    end else if (lvl != tgt) begin
      if ({1'b0, cnt} + 7'h1 >= period) begin
        next_cnt = 6'h0;
        next_lvl = (lvl < tgt) ? lvl + 8'h1 : lvl - 8'h1;
      end else begin
        next_cnt = cnt + 6'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgt <= 8'h00;
      lvl <= 8'h00;
      cnt <= 6'h0;
    end else begin
      tgt <= next_tgt;
      lvl <= next_lvl;
      cnt <= next_cnt;
    end
  end

  assign rmp.level = lvl;
  assign rmp.moving = (lvl != tgt);

  a_ramp_one_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (lvl != $past(lvl)) |-> (lvl - $past(lvl) == 8'h01 || $past(lvl) - lvl == 8'h01))
    else $error("ramp moved more than one code");
endmodule
`default_nettype wire

// ==== design/icvt_ramp_if.sv ====
/*
 * Carries the voltage ramp request and state between the bank and its ramp.
 * Assumes both ends share one clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface icvt_ramp_if;
  logic [7:0] target;
  logic load;
  logic [3:0] fast_slew;
  logic [7:0] level;
  logic moving;
  modport bank (output target, output load, output fast_slew, input level, input moving);
  modport ramp (input target, input load, input fast_slew, output level, output moving);
endinterface
`default_nettype wire

// ==== design/icvt_regs.sv ====
/*
 * Byte registers for input-current trim, output-voltage target and the
 * commanded-code readback, plus the trimmed current reading.
 * Assumes a byte-wide register port decoded from the two-wire bus engine,
 * which takes the acknowledge decision in the cycle after the write strobe.
 */
`timescale 1ns/10ps
`default_nettype none
`include "icvt_defs.svh"
module icvt_regs #(
  parameter int unsigned UPDATE_CYC = `ICVT_UPDATE_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire icvt_pkg::icvt_byte_t reg_wdata_i,
  output var icvt_pkg::icvt_byte_t reg_rdata_o,
  output logic reg_ack_o,
  output logic reg_nack_o,
  // Nonvolatile defaults, loaded on nvm_load_i
  input wire logic nvm_load_i,
  input wire icvt_pkg::icvt_byte_t nvm_cur_cal_i,
  input wire icvt_pkg::icvt_byte_t nvm_vout_tgt_i,
  // Configuration from other registers
  input wire logic [1:0] voltage_control_source_select_i,
  input wire logic [1:0] protocol_identifier_field_i,
  input wire logic [3:0] fast_slew_i,
  input wire icvt_pkg::icvt_pwr_t pwr_state_i,
  // Voltage-ID bus
  input wire logic vid_bus_set_i,
  input wire icvt_pkg::icvt_byte_t vid_bus_code_i,
  // Telemetry
  input wire logic [11:0] adc_iin_i,
  input wire logic adc_valid_i,
  output logic [11:0] input_current_reading_o,
  // Converter control
  output logic [7:0] vout_level_o,
  output logic vout_moving_o,
  output logic step_5mv_o,
  output logic [7:0] commanded_voltage_readback_o
);
  import icvt_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Offset in units of 0.25 A: codes 0 to 7 give -8 to -1, codes 8 to 14 give +1 to +7.
  // Code 15 repeats +7 so that the positive range stops at +1.75 A.
  function automatic logic [11:0] ofs_q(input logic [3:0] code);
    if (!code[3]) begin
      ofs_q = 12'({8'h00, code} - `ICVT_OFS_NEG_BASE);
    end else if (code == `ICVT_OFS_TOP_CODE) begin
      ofs_q = `ICVT_OFS_POS_BASE;
    end else begin
      ofs_q = 12'({8'h00, code} - `ICVT_OFS_POS_BASE);
    end
  endfunction

  // Gain in units of 0.5 percent, -7 .. +8.
  function automatic logic signed [4:0] gain_half_pct(input logic [3:0] code);
    gain_half_pct = $signed({1'b0, code}) - 5'sd7;
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  icvt_byte_t cur_cal, next_cur_cal;
  icvt_byte_t vout_tgt, next_vout_tgt;
  icvt_byte_t last_cmd, next_last_cmd;
  icvt_byte_t readback, next_readback;
  icvt_byte_t rdata, next_rdata;
  logic ack, next_ack, nack, next_nack, load, next_load;
  logic [11:0] reading, next_reading;
  logic [31:0] tick, next_tick;
  logic wr_tgt_ok;
  logic signed [24:0] scaled;

  icvt_ramp_if rif();
  icvt_ramp u_ramp (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .rmp(rif)
  );

  assign rif.target = last_cmd;
  assign rif.load = load;
  assign rif.fast_slew = fast_slew_i;

  always_comb begin
    wr_tgt_ok = pwr_state_i == ICVT_RUN || pwr_state_i == ICVT_OFF;
    next_cur_cal = cur_cal;
    next_vout_tgt = vout_tgt;
    next_last_cmd = last_cmd;
    next_readback = readback;
    next_rdata = rdata;
    next_ack = 1'b0;
    next_nack = 1'b0;
    next_load = 1'b0;
    next_tick = tick;
    next_reading = reading;
    scaled = 25'sd0;
    if (nvm_load_i) begin
      next_cur_cal = nvm_cur_cal_i;
      next_vout_tgt = nvm_vout_tgt_i;
      next_last_cmd = nvm_vout_tgt_i;
      next_load = 1'b1;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `ICVT_OFS_CUR_CAL: begin
          next_cur_cal = reg_wdata_i;
          next_ack = 1'b1;
        end
        `ICVT_OFS_VOUT_TGT: begin
          if (wr_tgt_ok) begin
            next_vout_tgt = reg_wdata_i;
            next_ack = 1'b1;
            if (voltage_control_source_select_i == `ICVT_SRC_I2C) begin
              next_last_cmd = reg_wdata_i;
              next_load = 1'b1;
            end
          end else begin
            next_nack = 1'b1;
          end
        end
        default: next_nack = 1'b1;
      endcase
    end else if (vid_bus_set_i) begin
      next_last_cmd = vid_bus_code_i;
      next_load = 1'b1;
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `ICVT_OFS_CUR_CAL: next_rdata = cur_cal;
        `ICVT_OFS_VOUT_TGT: next_rdata = vout_tgt;
        `ICVT_OFS_VID_RB: next_rdata = readback;
        default: next_rdata = 8'h00;
      endcase
      next_ack = 1'b1;
    end
    if (tick + 32'h1 >= 32'(UPDATE_CYC)) begin
      next_tick = 32'h0;
      next_readback = last_cmd;
    end else begin
      next_tick = tick + 32'h1;
    end
    if (adc_valid_i) begin
      // Gain first (0.5 percent steps), then unclamped offset add.
      scaled = $signed({13'h0, adc_iin_i}) * 25'(gain_half_pct(
        cur_cal[`ICVT_GAIN_MSB:`ICVT_GAIN_LSB])) / 25'sd200;
      next_reading = 12'(scaled + $signed({13'h0, adc_iin_i}))
        + ofs_q(cur_cal[`ICVT_OFS_MSB:`ICVT_OFS_LSB]);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_cal <= 8'h00;
      vout_tgt <= 8'h00;
      last_cmd <= 8'h00;
      readback <= 8'h00;
      rdata <= 8'h00;
      ack <= 1'b0;
      nack <= 1'b0;
      load <= 1'b0;
      tick <= 32'h0;
      reading <= 12'h000;
    end else begin
      cur_cal <= next_cur_cal;
      vout_tgt <= next_vout_tgt;
      last_cmd <= next_last_cmd;
      readback <= next_readback;
      rdata <= next_rdata;
      ack <= next_ack;
      nack <= next_nack;
      load <= next_load;
      tick <= next_tick;
      reading <= next_reading;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic [7:0] lvl_q;
  logic mov_q, step_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lvl_q <= 8'h00;
      mov_q <= 1'b0;
      step_q <= 1'b0;
    end else begin
      lvl_q <= rif.level;
      mov_q <= rif.moving;
      step_q <= protocol_identifier_field_i[0] ^ protocol_identifier_field_i[1];
    end
  end

  assign reg_rdata_o = rdata;
  assign reg_ack_o = ack;
  assign reg_nack_o = nack;
  assign input_current_reading_o = reading;
  assign vout_level_o = lvl_q;
  assign vout_moving_o = mov_q;
  assign step_5mv_o = step_q;
  assign commanded_voltage_readback_o = readback;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_nack_soft_ramp: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (reg_wr_i && !nvm_load_i && reg_addr_i == `ICVT_OFS_VOUT_TGT
     && (pwr_state_i == ICVT_SOFT_START || pwr_state_i == ICVT_SOFT_STOP))
    |=> reg_nack_o && !reg_ack_o && $stable(vout_tgt))
    else $error("target write not refused");
  a_ack_after_start: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (reg_wr_i && !nvm_load_i && reg_addr_i == `ICVT_OFS_VOUT_TGT && pwr_state_i == ICVT_RUN)
    |=> reg_ack_o && vout_tgt == $past(reg_wdata_i))
    else $error("target write not taken");
  a_src_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (reg_wr_i && !nvm_load_i && voltage_control_source_select_i != `ICVT_SRC_I2C)
    |=> !load)
    else $error("target steered with wrong source");
  a_redirect_now: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    load |=> u_ramp.tgt == $past(last_cmd))
    else $error("ramp not redirected");
  a_rb_readonly: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (reg_wr_i && !nvm_load_i && reg_addr_i == `ICVT_OFS_VID_RB) |=> reg_nack_o)
    else $error("readback write acked");
  a_rb_sync: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (tick == 32'(UPDATE_CYC) - 32'h1) |=> readback == $past(last_cmd))
    else $error("readback not refreshed");
  a_rb_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (tick != 32'(UPDATE_CYC) - 32'h1) |=> $stable(readback))
    else $error("readback changed off tick");
  a_step_select: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ##1 step_5mv_o == ($past(protocol_identifier_field_i) == 2'h1
      || $past(protocol_identifier_field_i) == 2'h2))
    else $error("step size wrong");
  a_offset_wrap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (adc_valid_i && adc_iin_i == 12'h000 && cur_cal == 8'h70) |=> reading == 12'hFF8)
    else $error("negative offset did not wrap");

  c_nack: cover property (@(posedge sys_clk_i) reg_nack_o && pwr_state_i == ICVT_SOFT_START);
  c_retarget: cover property (@(posedge sys_clk_i) load && vout_moving_o);
  c_vid_set: cover property (@(posedge sys_clk_i) vid_bus_set_i ##1 load);
  c_rb_read: cover property (@(posedge sys_clk_i) reg_rd_i && reg_addr_i == `ICVT_OFS_VID_RB);
endmodule
`default_nettype wire

// ==== sim/icvt_vid_master.sv ====
/*
 * Voltage-ID bus master model that hands commanded codes to the bank.
 * Assumes the bank samples the set strobe on the rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module icvt_vid_master (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic send_i,
  input wire logic [7:0] code_i,
  // Voltage-ID bus
  output logic vid_bus_set_o,
  output logic [7:0] vid_bus_code_o
);
  logic [7:0] last;
  // Between transfers the code lines show the inverse of the last code.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vid_bus_set_o <= 1'b0;
      vid_bus_code_o <= 8'h00;
      last <= 8'h00;
    end else if (send_i) begin
      vid_bus_set_o <= 1'b1;
      vid_bus_code_o <= code_i;
      last <= code_i;
    end else begin
      vid_bus_set_o <= 1'b0;
      vid_bus_code_o <= ~last;
    end
  end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
/*
 * Self-checking bench of the trim and voltage-target bank.
 * Assumes the bank answers one cycle after each register strobe.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import icvt_pkg::*;
  logic sys_clk_i, rst_i, reg_wr, reg_rd, nvm_load, adc_valid, vid_send, vid_set;
  logic ack, nack, moving, step5;
  logic [7:0] addr, vid_code, lvl, rb, l0, vcode;
  icvt_byte_t wdata, rdata, nvm_cal, nvm_tgt, got;
  logic [1:0] src, pid;
  logic [3:0] slew;
  icvt_pwr_t pwr;
  logic [11:0] adc, iin;
  int n_errors = 0;
  int checks = 0;
  logic [7:0] cal_tab [6] = '{8'h78, 8'h7F, 8'hF8, 8'h08, 8'h77, 8'h70};
  logic [11:0] adc_tab [6] = '{12'h064, 12'h064, 12'h0C8, 12'h0C8, 12'h064, 12'h000};
  logic [11:0] exp_tab [6] = '{12'h065, 12'h06B, 12'h0D1, 12'h0C2, 12'h063, 12'hFF8};

  icvt_regs #(.UPDATE_CYC(8)) uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .reg_addr_i(addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_nack_o(nack), .nvm_load_i(nvm_load),
    .nvm_cur_cal_i(nvm_cal), .nvm_vout_tgt_i(nvm_tgt),
    .voltage_control_source_select_i(src), .protocol_identifier_field_i(pid),
    .fast_slew_i(slew), .pwr_state_i(pwr), .vid_bus_set_i(vid_set),
    .vid_bus_code_i(vid_code), .adc_iin_i(adc), .adc_valid_i(adc_valid),
    .input_current_reading_o(iin), .vout_level_o(lvl), .vout_moving_o(moving),
    .step_5mv_o(step5), .commanded_voltage_readback_o(rb));

  icvt_vid_master vid (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .send_i(vid_send),
    .code_i(vcode), .vid_bus_set_o(vid_set), .vid_bus_code_o(vid_code));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // One strobe, then the answer is looked at in the cycle that follows.
  task automatic access(input logic wr, input logic [7:0] a, input icvt_byte_t d,
                        input logic ok);
    @(posedge sys_clk_i);
    reg_wr <= wr;
    reg_rd <= ~wr;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk_i);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    chk("ack", {31'h0, ok}, {31'h0, ack});
    chk("nack", {31'h0, ~ok}, {31'h0, nack});
    got = rdata;
  endtask

  task automatic conclude();
    $display("TB: errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and tests
  // ****************************************************************
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    #150000;
    n_errors++;
    conclude();
  end

  initial begin
    rst_i = 1'b1;
    {reg_wr, reg_rd, nvm_load, adc_valid, vid_send} = 5'h00;
    {addr, wdata, nvm_cal, nvm_tgt, vcode} = 40'h0;
    src = 2'h2;
    pid = 2'h0;
    slew = 4'h0;
    pwr = ICVT_OFF;
    adc = 12'h000;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    chk("rb_reset", 8'h00, rb);
    @(posedge sys_clk_i);
    nvm_load <= 1'b1;
    nvm_cal <= 8'h78;
    nvm_tgt <= 8'h40;
    @(posedge sys_clk_i);
    nvm_load <= 1'b0;
    access(1'b0, 8'hA5, 8'h00, 1'b1);
    chk("cal_nvm", 8'h78, got);
    access(1'b0, 8'hA6, 8'h00, 1'b1);
    chk("tgt_nvm", 8'h40, got);
    repeat (300) @(posedge sys_clk_i);
    #1;
    chk("rb_boot", 8'h40, rb);
    chk("lvl_boot", 8'h40, lvl);
    pwr <= ICVT_SOFT_START;
    access(1'b1, 8'hA6, 8'h11, 1'b0);
    pwr <= ICVT_SOFT_STOP;
    access(1'b1, 8'hA6, 8'h12, 1'b0);
    access(1'b0, 8'hA6, 8'h00, 1'b1);
    chk("tgt_refused", 8'h40, got);
    pwr <= ICVT_RUN;
    access(1'b1, 8'hA6, 8'h50, 1'b1);
    repeat (10) @(posedge sys_clk_i);
    #1;
    chk("moving", 1, moving);
    chk("quarter_slew", 1, lvl > 8'h40 && lvl < 8'h46);
    l0 = lvl;
    access(1'b1, 8'hA6, 8'h30, 1'b1);
    repeat (20) @(posedge sys_clk_i);
    #1;
    chk("redirect", 1, lvl < l0);
    repeat (100) @(posedge sys_clk_i);
    #1;
    chk("lvl_new", 8'h30, lvl);
    chk("rb_i2c", 8'h30, rb);
    src <= 2'h1;
    access(1'b1, 8'hA6, 8'h60, 1'b1);
    access(1'b0, 8'hA6, 8'h00, 1'b1);
    chk("tgt_stored", 8'h60, got);
    repeat (40) @(posedge sys_clk_i);
    #1;
    chk("lvl_held", 8'h30, lvl);
    src <= 2'h2;
    @(posedge sys_clk_i);
    vcode <= 8'h22;
    vid_send <= 1'b1;
    @(posedge sys_clk_i);
    vid_send <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    #1;
    chk("rb_vid", 8'h22, rb);
    access(1'b1, 8'hA7, 8'h99, 1'b0);
    repeat (20) @(posedge sys_clk_i);
    access(1'b0, 8'hA7, 8'h00, 1'b1);
    chk("rb_read", 8'h22, got);
    access(1'b1, 8'h10, 8'hFF, 1'b0);
    access(1'b0, 8'h10, 8'h00, 1'b1);
    chk("unmapped", 8'h00, got);
    for (int i = 0; i < 4; i++) begin
      pid <= i[1:0];
      repeat (3) @(posedge sys_clk_i);
      #1;
      chk("step_5mv", (i == 1 || i == 2), step5);
    end
    // The last two rows use negative offset codes; the last one breaks the
    // host guideline on purpose, with zero current, to show the wrap.
    for (int i = 0; i < 6; i++) begin
      access(1'b1, 8'hA5, cal_tab[i], 1'b1);
      adc <= adc_tab[i];
      adc_valid <= 1'b1;
      @(posedge sys_clk_i);
      adc_valid <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk("iin_reading", exp_tab[i], iin);
    end
    conclude();
  end
endmodule
`default_nettype wire
